// ==== eea_cpu_model.sv ====
// cpu model running the access sequences on the register port
module eea_cpu_model (
  input wire logic sys_clk_i,
  input wire logic busy_i,
  output logic [3:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  output logic reg_we_o,
  output logic reg_re_o
);
  import eea_pkg::*;
  // bus starts quiet
  initial begin
    reg_addr_o = 4'h0;
    reg_wdata_o = 8'h00;
    reg_we_o = 1'b0;
    reg_re_o = 1'b0;
  end
  // one bus cycle, changed just after an edge
  task automatic cyc(input logic w, input logic r, input logic [3:0] a, input logic [7:0] d);
    reg_we_o <= w;
    reg_re_o <= r;
    reg_addr_o <= a;
    reg_wdata_o <= d;
    @(posedge sys_clk_i);
  endtask
  // enable, then trigger next cycle, interrupts taken as masked around it
  task automatic op(input logic [7:0] en, input logic [7:0] tr, output int n);
    cyc(1'b1, 1'b0, EEA_IDX_CTRL, en);
    cyc(1'b1, 1'b0, EEA_IDX_CTRL, tr);
    n = 0;
    #1;
    // poll, never sleeping; a stray erase pair must be locked out
    while (busy_i && n < 2000) begin
      n++;
      cyc(n inside {2, 3}, 1'b0, EEA_IDX_CTRL, n == 3 ? 8'h30 : 8'h20);
      #1;
    end
  endtask
endmodule

// ==== eea_ctrl.sv ====
// emulated eeprom access controller with register port and cpu stall
//
// The address map and the plain strobed port were decided locally.
module eea_ctrl #(
  parameter int BASE_CYCLES = eea_pkg::EEA_BASE_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [7:0] reg_rdata_o,
  output logic cpu_stall_o,
  output logic busy_o
);
  import eea_pkg::*;

  typedef struct packed {
    logic [4:0] addr;
    logic [7:0][7:0] data;
    logic [7:0] ctrl;
    eea_op_t op;
    logic [23:0] timer;
    logic wen_prev;
    logic een_prev;
    logic [7:0] rdata;
    logic stall;
  } eea_ctrl_t;

  eea_ctrl_t q, d;
  logic [14:0] rd_word;
  logic [59:0] wr_words;
  logic wr_commit;
  logic er_commit;

  //----------------------------------------------------------------------
  // helpers
  //----------------------------------------------------------------------
  // erase or write time: base time doubled per select step
  function automatic logic [23:0] cycle_time(input logic [1:0] sel);
    logic [23:0] base;
    base = 24'(BASE_CYCLES);
    return base << sel;
  endfunction

  // high data bytes carry seven bits, top bit reads zero
  function automatic logic [7:0] mask_data(input logic [3:0] idx, input logic [7:0] v);
    return idx[0] ? v : {1'b0, v[6:0]};
  endfunction

  // the stored word pairs, word0 in the low 15 bits
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wr_words[i*15 +: 15] = {q.data[2*i+1][6:0], q.data[2*i]};
    end
  end

  //----------------------------------------------------------------------
  // next state
  //----------------------------------------------------------------------
  always_comb begin
    logic ctrl_wr;
    logic finish;
    ctrl_wr = reg_we_i && reg_addr_i == EEA_IDX_CTRL;
    finish = q.op != EEA_IDLE && q.timer == 24'h000001;
    d = q;
    wr_commit = 1'b0;
    er_commit = 1'b0;
    // remember enable sets so the trigger can be checked next cycle
    d.wen_prev = ctrl_wr && reg_wdata_i[EEA_WR_EN] && !reg_wdata_i[EEA_WR_TRIG];
    d.een_prev = ctrl_wr && reg_wdata_i[EEA_ER_EN] && !reg_wdata_i[EEA_ER_TRIG];

    // plain register writes
    if (reg_we_i) begin
      if (reg_addr_i == EEA_IDX_ADDR) begin
        d.addr = reg_wdata_i[4:0];
      end else if (reg_addr_i >= EEA_IDX_DATA0L && reg_addr_i <= EEA_IDX_DATA3H) begin
        d.data[3'(reg_addr_i - 4'h1)] = mask_data(reg_addr_i, reg_wdata_i);
      end else if (ctrl_wr && q.op == EEA_IDLE) begin
        // triggers only count with their enable already set
        d.ctrl = reg_wdata_i;
        d.ctrl[EEA_RD_TRIG] = 1'b0;
        d.ctrl[EEA_WR_TRIG] = 1'b0;
        d.ctrl[EEA_ER_TRIG] = 1'b0;
        if (reg_wdata_i[EEA_ER_TRIG] && q.ctrl[EEA_ER_EN] && q.een_prev) begin
          // erase trigger must land right after its enable
          d.ctrl[EEA_ER_TRIG] = 1'b1;
          d.op = EEA_ERASE;
          d.timer = cycle_time(reg_wdata_i[EEA_TSEL_LSB +: 2]);
          d.stall = 1'b1;
        end else if (reg_wdata_i[EEA_WR_TRIG] && q.ctrl[EEA_WR_EN] && q.wen_prev) begin
          // consecutive enable then trigger
          d.ctrl[EEA_WR_TRIG] = 1'b1;
          d.op = EEA_WRITE;
          d.timer = cycle_time(reg_wdata_i[EEA_TSEL_LSB +: 2]);
          d.stall = 1'b1;
        end else if (reg_wdata_i[EEA_RD_TRIG] && q.ctrl[EEA_RD_EN]) begin
          d.ctrl[EEA_RD_TRIG] = 1'b1;
          d.op = EEA_READ;
          d.timer = EEA_READ_CYCLES;
          d.stall = 1'b1;
        end
      end
      // control writes while busy leave ctrl unchanged but still update the enable history
    end

    // running operation
    if (q.op != EEA_IDLE) begin
      d.timer = q.timer - 24'h000001;
      if (finish) begin
        d.op = EEA_IDLE;
        d.stall = 1'b0;
        d.timer = '0;
        case (q.op)
          EEA_READ: begin
            d.ctrl[EEA_RD_TRIG] = 1'b0;
            d.ctrl[EEA_RD_EN] = 1'b0;
            d.data[0] = rd_word[7:0];
            d.data[1] = {1'b0, rd_word[14:8]};
          end
          EEA_WRITE: begin
            wr_commit = 1'b1;
            d.ctrl[EEA_WR_TRIG] = 1'b0;
            d.ctrl[EEA_WR_EN] = 1'b0;
          end
          default: begin
            er_commit = 1'b1;
            d.ctrl[EEA_ER_TRIG] = 1'b0;
            d.ctrl[EEA_ER_EN] = 1'b0;
          end
        endcase
      end
    end

    // read data one cycle after the strobe, unmapped reads zero
    d.rdata = 8'h00;
    if (reg_re_i) begin
      if (reg_addr_i == EEA_IDX_ADDR) begin
        d.rdata = {3'b000, q.addr};
      end else if (reg_addr_i >= EEA_IDX_DATA0L && reg_addr_i <= EEA_IDX_DATA3H) begin
        d.rdata = q.data[3'(reg_addr_i - 4'h1)];
      end else if (reg_addr_i == EEA_IDX_CTRL) begin
        d.rdata = q.ctrl;
      end
    end

    if (srst_i) begin
      d.addr = EEA_ADDR_RST;
      d.data = '0;
      d.ctrl = EEA_CTRL_RST;
      d.op = EEA_IDLE;
      d.timer = '0;
      d.wen_prev = 1'b0;
      d.een_prev = 1'b0;
      d.rdata = 8'h00;
      d.stall = 1'b0;
      wr_commit = 1'b0;
      er_commit = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    q <= d;
  end

  //----------------------------------------------------------------------
  // word array
  //----------------------------------------------------------------------
  // write unit from address bits 4..2, page from bit 4
  eea_store #(
    .WORDS(32),
    .WIDTH(15)
  ) u_store (
    .sys_clk_i(sys_clk_i),
    .wr_commit_i(wr_commit),
    .wr_unit_i(q.addr[4:2]),
    .wr_words_i(wr_words),
    .er_commit_i(er_commit),
    .er_page_i(q.addr[4]),
    .rd_addr_i(q.addr),
    .rd_word_o(rd_word)
  );

  assign reg_rdata_o = q.rdata;
  assign cpu_stall_o = q.stall;
  assign busy_o = q.stall;
endmodule

// ==== eea_ctrl_properties.sv ====
// assertions on the eeprom access controller ports
module eea_ctrl_properties #(
  parameter int BASE_CYCLES = 8
) (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic cpu_stall_o,
  input wire logic busy_o
);
  import eea_pkg::*;
  logic iw;
  logic [7:0] last_q;
  int run_q;
  int want;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  // control write while idle, the only way an operation can start
  assign iw = !cpu_stall_o && reg_we_i && reg_addr_i == EEA_IDX_CTRL;
  // reads have a fixed length, erase and write follow the time select
  assign want = |last_q[5:2] ? BASE_CYCLES << last_q[7:6] : int'(EEA_READ_CYCLES);
  // last idle control byte and length of the running stall
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      last_q <= 8'h00;
      run_q <= 0;
    end else begin
      if (iw) last_q <= reg_wdata_i;
      run_q <= cpu_stall_o ? run_q + 1 : 0;
    end
  end
  sequence s_pair(logic [7:0] e, logic [7:0] t);
    iw && reg_wdata_i == e ##1 iw && reg_wdata_i == t;
  endsequence
  property p_busy; busy_o == cpu_stall_o; endproperty
  property p_wr; s_pair(8'h08, 8'h0C) |=> cpu_stall_o; endproperty
  property p_er; s_pair(8'h20, 8'h30) |=> cpu_stall_o; endproperty
  property p_rd; s_pair(8'h02, 8'h03) |=> cpu_stall_o; endproperty
  property p_cause; $rose(cpu_stall_o) |-> $past(iw); endproperty
  property p_alone; iw && reg_wdata_i[5:0] == 6'h04 && !$past(iw) |=> !cpu_stall_o; endproperty
  property p_clr; reg_re_i && reg_addr_i == EEA_IDX_CTRL && !cpu_stall_o |=> (reg_rdata_o & 8'h15) == 8'h00; endproperty
  property p_len; $fell(cpu_stall_o) && !$past(srst_i) |-> run_q == want; endproperty
  a_busy: assert property (p_busy) else $error("busy differs from stall");
  a_wr: assert property (p_wr) else $error("write not started");
  a_er: assert property (p_er) else $error("erase not started");
  a_rd: assert property (p_rd) else $error("read not started");
  a_cause: assert property (p_cause) else $error("stall without start");
  a_alone: assert property (p_alone) else $error("lone trigger started");
  a_clr: assert property (p_clr) else $error("trigger left set");
  a_len: assert property (p_len) else $error("stall length wrong");
endmodule

bind eea_ctrl eea_ctrl_properties #(.BASE_CYCLES(BASE_CYCLES)) u_prop (
  .sys_clk_i(sys_clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .cpu_stall_o(cpu_stall_o),
  .busy_o(busy_o));

// ==== eea_store.sv ====
// package of constants and the emulated nonvolatile word array
//----------------------------------------------------------------------
// Summary of operation
// - a write stores four words; only the upper three address bits pick the unit
// - write starts only if trigger is set the cycle after enable
// - cpu is stalled for the whole write cycle, released when it ends
// - write trigger clears in hardware when the write cycle completes
// - read starts when trigger is set with read enable set; cpu stalls
// - read end clears read trigger and loads word into first data pair
// - read result stays in first data pair until another read or a data register write
// - erase and write triggers must follow their enables immediately
// - control bits 7..6 select 2, 4, 8 or 16 ms erase or write time
// - erase clears one 16 word page picked by the top address bit to zero
// - a trigger is ignored unless its enable was already set before
//----------------------------------------------------------------------
package eea_pkg;
  // register indexes on the plain register port
  localparam logic [3:0] EEA_IDX_ADDR = 4'h0;
  localparam logic [3:0] EEA_IDX_DATA0L = 4'h1;
  localparam logic [3:0] EEA_IDX_DATA3H = 4'h8;
  localparam logic [3:0] EEA_IDX_CTRL = 4'h9;
  // control register field positions
  localparam int EEA_RD_TRIG = 0;
  localparam int EEA_RD_EN = 1;
  localparam int EEA_WR_TRIG = 2;
  localparam int EEA_WR_EN = 3;
  localparam int EEA_ER_TRIG = 4;
  localparam int EEA_ER_EN = 5;
  localparam int EEA_TSEL_LSB = 6;
  localparam logic [7:0] EEA_CTRL_RST = 8'h00;
  localparam logic [4:0] EEA_ADDR_RST = 5'h00;
  localparam logic [7:0] EEA_DATA_RST = 8'h00;
  // timing
  localparam int EEA_CLK_HZ = 125000000;
  localparam int EEA_BASE_TIME_US = 2000;
  localparam int EEA_BASE_CYCLES = EEA_CLK_HZ / 1000000 * EEA_BASE_TIME_US;
  localparam logic [23:0] EEA_READ_CYCLES = 24'h000004;
  typedef enum logic [1:0] {
    EEA_IDLE = 2'b00,
    EEA_READ = 2'b01,
    EEA_WRITE = 2'b10,
    EEA_ERASE = 2'b11
  } eea_op_t;
endpackage

// word array: four word unit commit, page erase, combinational read
module eea_store #(
  parameter int WORDS = 32,
  parameter int WIDTH = 15
) (
  input wire logic sys_clk_i,
  input wire logic wr_commit_i,
  input wire logic [2:0] wr_unit_i,
  input wire logic [4*WIDTH-1:0] wr_words_i,
  input wire logic er_commit_i,
  input wire logic er_page_i,
  input wire logic [4:0] rd_addr_i,
  output logic [WIDTH-1:0] rd_word_o
);
  import eea_pkg::*;
  typedef struct packed {
    logic [WORDS-1:0][WIDTH-1:0] mem;
  } eea_store_t;
  eea_store_t q, d;

  // contents are nonvolatile, so reset leaves them alone
  always_comb begin
    d = q;
    if (wr_commit_i) begin
      for (int i = 0; i < 4; i++) begin
        d.mem[{wr_unit_i, 2'(i)}] = wr_words_i[i*WIDTH +: WIDTH];
      end
    end else if (er_commit_i) begin
      for (int i = 0; i < 16; i++) begin
        d.mem[{er_page_i, 4'(i)}] = '0;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    q <= d;
  end

  assign rd_word_o = q.mem[rd_addr_i];
endmodule

// ==== emulated_eeprom_access_tb_top.sv ====
// self-checking bench for the eeprom access controller
module emulated_eeprom_access_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import eea_pkg::*;
  localparam int B = 8;
  logic sys_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [3:0] addr;
  logic [7:0] wdata, rdata;
  logic we, re, busy, stall;
  logic re_d = 1'b0;
  int n_errors = 0;
  int cmp_count = 0;
  int n;
  logic [7:0] exp_q[$];
  logic [14:0] dw[16];
  logic [31:0] rnd = 32'h00010BA6;
  eea_ctrl #(.BASE_CYCLES(B)) u_dut (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata), .cpu_stall_o(stall), .busy_o(busy));
  eea_cpu_model u_cpu (.sys_clk_i(sys_clk_i), .busy_i(busy), .reg_addr_o(addr), .reg_wdata_o(wdata),
    .reg_we_o(we), .reg_re_o(re));
  initial forever #4 sys_clk_i = ~sys_clk_i;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] e);
    cmp_count++;
    if (got !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, e);
    end
  endtask
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_cpu.cyc(1'b0, 1'b1, a, 8'h00);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    u_cpu.cyc(1'b1, 1'b0, a, d);
  endtask
  task automatic run(input logic [7:0] en, input logic [7:0] tr, input logic [31:0] e);
    u_cpu.op(en, tr, n);
    check(n, e);
  endtask
  // read answers are settled half a cycle after their edge
  always @(posedge sys_clk_i) re_d <= re;
  always @(negedge sys_clk_i) if (re_d) check(rdata, exp_q.pop_front());
  // hang guard, far beyond the expected run
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    n_errors++;
    stop_test();
  end
  initial begin
    repeat (16) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    rd(EEA_IDX_CTRL, EEA_CTRL_RST);
    rd(EEA_IDX_ADDR, {3'b000, EEA_ADDR_RST});
    rd(4'hF, 8'h00);
    wr(EEA_IDX_ADDR, 8'h00);
    run(8'h20, 8'h30, B);
    wr(EEA_IDX_ADDR, 8'h13);
    run(8'hE0, 8'hF0, B * 8);
    $display("erase test done");
    for (int u = 0; u < 4; u++) begin
      for (int i = 0; i < 8; i++) begin
        rnd = lfsr(rnd);
        if (i[0] == 1'b0) dw[u * 4 + i / 2] = rnd[14:0];
        wr(4'(EEA_IDX_DATA0L + i), i[0] ? {1'b0, dw[u * 4 + i / 2][14:8]} : rnd[7:0]);
      end
      wr(EEA_IDX_ADDR, 8'(u * 4 + 3));
      run({2'(u), 6'h08}, {2'(u), 6'h0C}, B << u);
      rd(EEA_IDX_CTRL, {2'(u), 6'h00});
    end
    for (int a = 0; a < 17; a++) begin
      wr(EEA_IDX_ADDR, a < 16 ? 8'(a) : 8'h1C);
      run(8'h02, 8'h03, 32'(EEA_READ_CYCLES));
      rd(EEA_IDX_DATA0L, a < 16 ? dw[a][7:0] : 8'h00);
      rd(4'(EEA_IDX_DATA0L + 1), a < 16 ? {1'b0, dw[a][14:8]} : 8'h00);
    end
    $display("write and read test done");
    wr(EEA_IDX_CTRL, 8'h08);
    wr(EEA_IDX_ADDR, 8'h00);
    wr(EEA_IDX_CTRL, 8'h0C);
    rd(EEA_IDX_CTRL, 8'h08);
    wr(EEA_IDX_CTRL, 8'h04);
    rd(EEA_IDX_CTRL, 8'h00);
    rd(EEA_IDX_DATA0L, 8'h00);
    wr(EEA_IDX_CTRL, 8'h00);
    u_cpu.cyc(1'b0, 1'b0, 4'h0, 8'h00);
    u_cpu.cyc(1'b0, 1'b0, 4'h0, 8'h00);
    $display("ignored trigger test done");
    stop_test();
  end
endmodule
